// *** src/hbdp_beat_engine.sv ***
/* Beat engine: drives one four-beat line onto the data pins with group
   inversion and strobes, and captures lines driven by the far end.
   Assumes the pins come from another clock domain and its owner starts
   a transfer only when the bus is free. */
`default_nettype none
`include "hbdp_defs.svh"
module hbdp_beat_engine
   import hbdp_pkg::*;
(
   input  wire logic          core_clk,   // Core clock
   input  wire logic          srst,       // Sync reset, active high
   input  wire hbdp_pins_type pins,       // Resolved bus pins
   input  wire logic [3:0]    par_in,     // Parity lines seen
   input  wire logic          par_chk,    // Check parity on capture
   output var  hbdp_pins_type pins_out,   // Pins this end drives
   output logic               pins_oe_n,  // Low while driving
   output logic [3:0]         par_out,    // Parity of driven beat
   input  wire logic          tx_start,   // Start a transfer, pulse
   input  wire hbdp_line_type tx_line,    // Line to drive, beat 0 low
   output logic               tx_busy,    // Transfer being driven
   output var  hbdp_line_type rx_line,    // Last captured line
   output logic               rx_valid,   // New captured line, pulse
   output logic               rx_par_err, // Parity fault in that line
   output logic               bus_busy    // Far end occupies the bus
);
   localparam int GW = `HBDP_GRP_W;
   localparam int BW = `HBDP_BUS_W;
   localparam logic [3:0] BEAT_LAST = 4'(`HBDP_BEAT_CYC - 1);
   localparam logic [3:0] STB_AT = 4'(`HBDP_STB_AT);

   typedef struct packed {
      hbdp_pins_type s1, s2;
      logic [3:0]    ev3, od3, p1, p2, ecnt, ocnt, par;
      logic          v3, tx_on, own, oe_n, valid, perr, perr_acc;
      logic [1:0]    beat;
      logic [3:0]    sub;
      hbdp_pins_type out;
      hbdp_word_type prev;
      hbdp_line_type cap, line;
   } hbdp_eng_state_type;

   hbdp_eng_state_type r_reg, r_next;
   hbdp_word_type prev_w, raw_w, enc_w, dec_w;
   logic [3:0] flip, par_w, fall_e, fall_o;
   logic [1:0] ld_beat;

   assign ld_beat = r_reg.tx_on ? r_reg.beat + 2'h1 : 2'h0;
   assign prev_w  = r_reg.tx_on ? r_reg.prev : {`HBDP_GROUPS{`HBDP_IDLE_GRP}};  // see [R17]
   assign raw_w   = tx_line[ld_beat * BW +: BW];
   assign fall_e  = r_reg.ev3 & ~r_reg.s2.even_beat_strobes;
   assign fall_o  = r_reg.od3 & ~r_reg.s2.odd_beat_strobes;

   for (genvar g = 0; g < `HBDP_GROUPS; g++) begin : g_grp
      assign flip[g] = hbdp_flip(prev_w[g*GW +: GW], raw_w[g*GW +: GW]);          // see [R1]
      assign enc_w[g*GW +: GW] = flip[g] ? ~raw_w[g*GW +: GW] : raw_w[g*GW +: GW]; // see [R3]
      assign par_w[g] = hbdp_par(enc_w[g*GW +: GW]);
      // Flag pin is active low: low means the group travels complemented
      assign dec_w[g*GW +: GW] = r_reg.s2.group_inversion_flags[g] ?
                                 r_reg.s2.data[g*GW +: GW] : ~r_reg.s2.data[g*GW +: GW]; // see [R2]
   end

   always_comb begin
      int slot;
      slot = 0;
      r_next = r_reg;
      r_next.s1 = pins;
      r_next.s2 = r_reg.s1;
      r_next.ev3 = r_reg.s2.even_beat_strobes;
      r_next.od3 = r_reg.s2.odd_beat_strobes;
      r_next.v3 = r_reg.s2.data_valid_n;
      r_next.p1 = par_in;
      r_next.p2 = r_reg.p1;
      r_next.valid = 1'b0;
      if (r_reg.tx_on) begin
         r_next.sub = r_reg.sub + 4'h1;
         if (r_reg.sub == BEAT_LAST) begin
            r_next.sub = 4'h0;
            if (r_reg.beat == 2'h3) begin
               r_next.tx_on = 1'b0;                                   // see [R14]
               r_next.oe_n = 1'b1;
               r_next.out = hbdp_pins_type'('1);
            end else begin
               r_next.beat = ld_beat;
            end
         end
      end else if (tx_start) begin
         r_next.tx_on = 1'b1;
         r_next.own = 1'b1;
         r_next.beat = 2'h0;                                          // see [R18]
         r_next.sub = 4'h0;
         r_next.oe_n = 1'b0;
      end
      if (r_next.tx_on && r_next.sub == 4'h0) begin
         r_next.out.data = enc_w;
         r_next.out.group_inversion_flags = ~flip;
         r_next.out.data_valid_n = 1'b0;                              // see [R7]
         r_next.out.data_bus_occupied_n = 1'b0;                       // see [R15]
         r_next.prev = enc_w;                                         // see [R17]
         r_next.par = par_w;
      end
      r_next.out.even_beat_strobes = '1;
      r_next.out.odd_beat_strobes = '1;
      if (r_next.tx_on && r_next.sub >= STB_AT) begin
         if (r_next.beat[0]) begin
            r_next.out.odd_beat_strobes = '0;                         // see [R4]
         end else begin
            r_next.out.even_beat_strobes = '0;                        // see [R5]
         end
      end
      if (!r_reg.s2.data_valid_n) begin                               // see [R7]
         for (int g = 0; g < `HBDP_GROUPS; g++) begin
            if (fall_e[g]) begin
               slot = {r_reg.ecnt[g], 1'b0};
               r_next.cap[slot*BW + g*GW +: GW] = dec_w[g*GW +: GW];  // see [R5] [R6]
               r_next.ecnt[g] = ~r_reg.ecnt[g];
            end
            if (fall_o[g]) begin
               slot = {r_reg.ocnt[g], 1'b1};
               r_next.cap[slot*BW + g*GW +: GW] = dec_w[g*GW +: GW];  // see [R4] [R6]
               r_next.ocnt[g] = ~r_reg.ocnt[g];
            end
            if ((fall_e[g] | fall_o[g]) && par_chk &&
                r_reg.p2[g] != hbdp_par(r_reg.s2.data[g*GW +: GW])) begin
               r_next.perr_acc = 1'b1;                                // see [R13]
            end
         end
      end else if (!r_reg.v3) begin
         // Valid just released: the line is complete, own echoes are dropped
         r_next.valid = !r_reg.own;
         if (!r_reg.own) begin
            r_next.line = r_reg.cap;
            r_next.perr = r_reg.perr_acc;
         end
         r_next.own = 1'b0;
         r_next.perr_acc = 1'b0;
         r_next.ecnt = '0;                                            // see [R18]
         r_next.ocnt = '0;
      end
      if (srst) begin
         r_next = '0;
         r_next.s1 = hbdp_pins_type'('1);
         r_next.s2 = hbdp_pins_type'('1);
         r_next.out = hbdp_pins_type'('1);
         r_next.ev3 = '1;
         r_next.od3 = '1;
         r_next.v3 = 1'b1;
         r_next.oe_n = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      r_reg <= r_next;
   end

   assign pins_out   = r_reg.out;
   assign pins_oe_n  = r_reg.oe_n;
   assign par_out    = r_reg.par;
   assign tx_busy    = r_reg.tx_on;
   assign rx_line    = r_reg.line;
   assign rx_valid   = r_reg.valid;
   assign rx_par_err = r_reg.perr;
   assign bus_busy   = !r_reg.s2.data_bus_occupied_n && !r_reg.own;
endmodule
`default_nettype wire

// *** src/hbdp_cpu_end.sv ***
/* Processor end of the host bus data phase: drives write lines when the
   target is ready, takes read lines, answers snoops and holds the lock.
   Assumes the bridge end makes the bus clock and all link inputs are
   asynchronous to core_clk. */
`default_nettype none
`include "hbdp_defs.svh"
module hbdp_cpu_end
   import hbdp_pkg::*;
#(
   parameter bit PARITY_CHECK = 1'b0            // Check parity lines on reads
)(
   input  wire logic            core_clk,       // Core clock, 100 MHz
   input  wire logic            srst,           // Sync reset, active high
   hbdp_link_if.cpu             link,           // Host bus pins
   input  wire logic            wr_valid,       // Write line offered
   output logic                 wr_ready,       // Write line can be taken
   input  wire hbdp_line_type   wr_line,        // Write line, beat 0 low
   input  wire logic            wr_lock,        // Write is part of an atomic run
   output logic                 wr_done,        // Write fully driven, pulse
   output logic                 wr_deferred,    // Write deferred by target, pulse
   output var  hbdp_line_type   rd_line,        // Last read line
   output logic                 rd_valid,       // New read line, pulse
   output logic                 rd_par_err,     // Parity fault on that line
   output logic                 rd_pending,     // Bridge announced a read return
   input  wire logic            snoop_req,      // Snoop inquiry active
   input  wire hbdp_lstate_type snoop_state,    // Cache state of inquiry line
   input  wire logic            lock_req        // Atomic sequence in progress
);
   typedef enum {C_IDLE, C_WAIT, C_SEND} hbdp_cpu_fsm_type;

   typedef struct packed {
      logic             bc1, bc2, bc3;
      logic             tr1, tr2;
      logic             df1, df2;
      logic             dp1, dp2;
      hbdp_cpu_fsm_type state;
      hbdp_line_type    line;
      logic             locked;
      logic             start;
      logic             done;
      logic             deferred;
      logic             hit_n;
      logic             snoop_dirty_match_n_n;
      logic             lock_n;
   } hbdp_cpu_state_type;

   hbdp_cpu_state_type r_reg, r_next;
   logic bclk_rise;
   logic tx_busy;
   logic bus_busy;
   logic take;

   assign bclk_rise = r_reg.bc2 && !r_reg.bc3;
   assign take = wr_valid && wr_ready;
   assign wr_ready = (r_reg.state == C_IDLE);

   hbdp_beat_engine u_engine (
      .core_clk   (core_clk),
      .srst       (srst),
      .pins       (link.pins),
      .par_in     (link.data_parity_lines),
      .par_chk    (PARITY_CHECK),
      .pins_out   (link.cpu_pins),
      .pins_oe_n  (link.cpu_oe_n),
      .par_out    (),
      .tx_start   (r_reg.start),
      .tx_line    (r_reg.line),
      .tx_busy    (tx_busy),
      .rx_line    (rd_line),
      .rx_valid   (rd_valid),
      .rx_par_err (rd_par_err),
      .bus_busy   (bus_busy)
   );

   always_comb begin
      r_next = r_reg;
      r_next.bc1 = link.bus_clock_true;
      r_next.bc2 = r_reg.bc1;
      r_next.bc3 = r_reg.bc2;
      r_next.tr1 = link.target_accepts_write_n;
      r_next.tr2 = r_reg.tr1;
      r_next.df1 = link.defer_n;
      r_next.df2 = r_reg.df1;
      r_next.dp1 = link.data_return_pending_n;
      r_next.dp2 = r_reg.dp1;
      r_next.start = 1'b0;
      r_next.done = 1'b0;
      r_next.deferred = 1'b0;
      case (r_reg.state)
         C_IDLE: begin
            if (take) begin
               r_next.line = wr_line;
               r_next.locked = wr_lock;
               r_next.state = C_WAIT;
            end
         end
         C_WAIT: begin
            if (!r_reg.df2) begin
               // Deferred: the line is dropped, the target completes it later
               r_next.deferred = 1'b1;                                    // see [R9]
               r_next.locked = 1'b0;
               r_next.state = C_IDLE;
            end else if (bclk_rise && !r_reg.tr2 && r_reg.dp2 && !bus_busy) begin
               // Start on a bus clock edge, only with the target ready,
               // no read return announced and nobody else on the bus
               r_next.start = 1'b1;                                       // see [R16] [R8] [R15]
               r_next.state = C_SEND;
            end
         end
         C_SEND: begin
            if (!r_reg.start && !tx_busy) begin
               r_next.done = 1'b1;
               r_next.locked = 1'b0;
               r_next.state = C_IDLE;
            end
         end
         default: begin
            r_next.state = C_IDLE;
         end
      endcase
      r_next.hit_n = !(snoop_req &&
                       (snoop_state == LS_SHARED || snoop_state == LS_EXCLUSIVE)); // see [R10]
      r_next.snoop_dirty_match_n_n = !(snoop_req && snoop_state == LS_MODIFIED);                  // see [R11]
      // Lock stays on until a locked write in flight has left the pins or been deferred
      r_next.lock_n = !(lock_req || r_next.locked);                                // see [R12]
      if (srst) begin
         r_next = '0;
         r_next.state = C_IDLE;
         r_next.bc1 = 1'b0;
         r_next.tr1 = 1'b1;
         r_next.tr2 = 1'b1;
         r_next.df1 = 1'b1;
         r_next.df2 = 1'b1;
         r_next.dp1 = 1'b1;
         r_next.dp2 = 1'b1;
         r_next.hit_n = 1'b1;
         r_next.snoop_dirty_match_n_n = 1'b1;
         r_next.lock_n = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      r_reg <= r_next;
   end

   assign wr_done                  = r_reg.done;
   assign wr_deferred              = r_reg.deferred;
   assign rd_pending               = !r_reg.dp2;                  // see [R8]
   assign link.snoop_hit_n         = r_reg.hit_n;
   assign link.snoop_dirty_match_n = r_reg.snoop_dirty_match_n_n;
   assign link.lock_n              = r_reg.lock_n;
endmodule
`default_nettype wire

// *** src/hbdp_defs.svh ***
/* Constants of the host bus data phase: widths, timing counts, idle levels.
   Assumes a 100 MHz core clock on both ends and a quad-pumped data bus. */
// Function
// [R1] Send group inverted when over half toggle
// [R2] Receiver re-inverts group when flag asserted
// [R3] Flag n covers data bits of group n
// [R4] Odd beats latched on odd strobe fall
// [R5] Even beats latched on even strobe fall
// [R6] Strobe pair n latches group n only
// [R7] Data valid asserted while data present
// [R8] Bridge flags pending data return beforehand
// [R9] Defer marks transaction deferred at processor
// [R10] Snoop hit on shared or exclusive line
// [R11] Dirty match on modified line
// [R12] Lock held over atomic bus sequence
// [R13] Parity lines optional, far end decides
// [R14] Four data beats per bus clock
// [R15] Data busy held while bus occupied
// [R16] Target ready only when write acceptable
// [R17] Inversion compares previous beat, idle first
// [R18] Beat count restarts at zero, even first
`ifndef HBDP_DEFS_SVH
`define HBDP_DEFS_SVH
`define HBDP_CORE_MHZ 100
`define HBDP_BCLK_NS 160
`define HBDP_BCLK_CYC (`HBDP_BCLK_NS * `HBDP_CORE_MHZ / 1000)
`define HBDP_BEATS 4
`define HBDP_BEAT_CYC (`HBDP_BCLK_CYC / `HBDP_BEATS)
`define HBDP_STB_AT 2
`define HBDP_GRP_W 16
`define HBDP_GROUPS 4
`define HBDP_BUS_W 64
`define HBDP_IDLE_GRP 16'hFFFF
`define HBDP_HALF 5'h08
`endif

// *** src/hbdp_link_if.sv ***
/* Pin bundle between the processor end and the bridge end.
   Assumes each end drives the shared data pins only with its enable low;
   undriven pins float high through the implied pull-ups. */
`default_nettype none
interface hbdp_link_if;
   import hbdp_pkg::*;
   hbdp_pins_type pins;
   hbdp_pins_type cpu_pins;
   hbdp_pins_type nb_pins;
   logic          cpu_oe_n;
   logic          nb_oe_n;
   logic          bus_clock_true;
   logic          bus_clock_comp;
   logic          data_return_pending_n;
   logic          defer_n;
   logic          target_accepts_write_n;
   logic [3:0]    data_parity_lines;
   logic          snoop_hit_n;
   logic          snoop_dirty_match_n;
   logic          lock_n;

   assign pins = !cpu_oe_n ? cpu_pins : (!nb_oe_n ? nb_pins : hbdp_pins_type'('1));

   modport cpu (input pins, bus_clock_true, bus_clock_comp, data_return_pending_n, defer_n,
                target_accepts_write_n, data_parity_lines,
                output cpu_pins, cpu_oe_n, snoop_hit_n, snoop_dirty_match_n, lock_n);
   modport bridge (input pins, snoop_hit_n, snoop_dirty_match_n, lock_n,
                   output nb_pins, nb_oe_n, bus_clock_true, bus_clock_comp,
                   data_return_pending_n, defer_n, target_accepts_write_n,
                   data_parity_lines);
endinterface
`default_nettype wire

// *** src/hbdp_nb_end.sv ***
/* Bridge end of the host bus data phase: makes the bus clock, returns
   read lines after announcing them, accepts write lines from the processor.
   Assumes processor-side pins are asynchronous to core_clk. */
`default_nettype none
`include "hbdp_defs.svh"
module hbdp_nb_end
   import hbdp_pkg::*;
#(
   parameter bit PARITY_EN = 1'b1               // Drive the parity lines
)(
   input  wire logic          core_clk,         // Core clock, 100 MHz
   input  wire logic          srst,             // Sync reset, active high
   hbdp_link_if.bridge        link,             // Host bus pins
   input  wire logic          ret_valid,        // Read line to return
   output logic               ret_ready,        // Read line can be taken
   input  wire hbdp_line_type ret_line,         // Read line, beat 0 low
   input  wire logic          accept_en,        // Able to take write data
   input  wire logic          defer_req,        // Defer the current transaction
   output var  hbdp_line_type wr_line,          // Last write line taken
   output logic               wr_valid,         // New write line, pulse
   output logic               snoop_hit,        // Processor reports clean hit
   output logic               snoop_dirty,      // Processor reports dirty hit
   output logic               lock_seen         // Processor holds the lock
);
   localparam logic [4:0] BCLK_LAST = 5'(`HBDP_BCLK_CYC - 1);
   localparam logic [4:0] BCLK_HALF = 5'(`HBDP_BCLK_CYC / 2);

   typedef enum {N_IDLE, N_PEND, N_SEND} hbdp_nb_fsm_type;
   typedef struct packed {
      logic [4:0]      div;
      logic            bclk;
      logic [2:0]      s1, s2;
      hbdp_nb_fsm_type state;
      logic            armed, start, data_return_pending_n_n, target_accepts_write_n_n, defer_n;
      hbdp_line_type   line;
   } hbdp_nb_state_type;

   hbdp_nb_state_type r_reg, r_next;
   logic tick, tx_busy, bus_busy;
   logic [3:0] par_out;

   assign tick = (r_reg.div == BCLK_LAST);
   assign ret_ready = (r_reg.state == N_IDLE);

   hbdp_beat_engine u_engine (
      .core_clk   (core_clk),
      .srst       (srst),
      .pins       (link.pins),
      .par_in     (4'hF),
      .par_chk    (1'b0),
      .pins_out   (link.nb_pins),
      .pins_oe_n  (link.nb_oe_n),
      .par_out    (par_out),
      .tx_start   (r_reg.start),
      .tx_line    (r_reg.line),
      .tx_busy    (tx_busy),
      .rx_line    (wr_line),
      .rx_valid   (wr_valid),
      .rx_par_err (),
      .bus_busy   (bus_busy)
   );

   always_comb begin
      r_next = r_reg;
      r_next.div = tick ? 5'h00 : r_reg.div + 5'h01;
      r_next.bclk = (r_next.div < BCLK_HALF);
      r_next.s1 = {link.snoop_hit_n, link.snoop_dirty_match_n, link.lock_n};
      r_next.s2 = r_reg.s1;
      r_next.start = 1'b0;
      case (r_reg.state)
         N_IDLE: begin
            if (ret_valid) begin
               r_next.line = ret_line;
               r_next.armed = 1'b0;
               r_next.data_return_pending_n_n = 1'b0;                                 // see [R8]
               r_next.state = N_PEND;
            end
         end
         N_PEND: begin
            // A full bus clock of warning before the return is driven
            if (tick && r_reg.armed && !bus_busy) begin
               r_next.start = 1'b1;
               r_next.data_return_pending_n_n = 1'b1;
               r_next.state = N_SEND;
            end else if (tick) begin
               r_next.armed = 1'b1;
            end
         end
         N_SEND: begin
            if (!r_reg.start && !tx_busy) begin
               r_next.state = N_IDLE;
            end
         end
         default: begin
            r_next.state = N_IDLE;
         end
      endcase
      r_next.target_accepts_write_n_n = !(accept_en && r_next.state == N_IDLE && !ret_valid);  // see [R16]
      r_next.defer_n = !defer_req;                                          // see [R9]
      if (srst) begin
         r_next = '0;
         r_next.state = N_IDLE;
         r_next.s1 = '1;
         r_next.s2 = '1;
         r_next.data_return_pending_n_n = 1'b1;
         r_next.target_accepts_write_n_n = 1'b1;
         r_next.defer_n = 1'b1;
         // Wraps at the first edge after release, so the first high phase is full
         r_next.div = BCLK_LAST;
      end
   end

   always_ff @(posedge core_clk) begin
      r_reg <= r_next;
   end

   assign link.bus_clock_true         = r_reg.bclk;                  // see [R14]
   assign link.bus_clock_comp         = !r_reg.bclk;
   assign link.data_return_pending_n  = r_reg.data_return_pending_n_n;
   assign link.defer_n                = r_reg.defer_n;
   assign link.target_accepts_write_n = r_reg.target_accepts_write_n_n;
   assign link.data_parity_lines      = PARITY_EN ? par_out : 4'hF;  // see [R13]
   assign snoop_hit                   = !r_reg.s2[2];
   assign snoop_dirty                 = !r_reg.s2[1];
   assign lock_seen                   = !r_reg.s2[0];
endmodule
`default_nettype wire

// *** src/hbdp_pkg.sv ***
/* Types and shared decode functions of the host bus data phase.
   Assumes hbdp_defs.svh is on the include path. */
`default_nettype none
`include "hbdp_defs.svh"
package hbdp_pkg;
   typedef logic [`HBDP_GRP_W-1:0]             hbdp_group_type;
   typedef logic [`HBDP_BUS_W-1:0]             hbdp_word_type;
   typedef logic [`HBDP_BEATS*`HBDP_BUS_W-1:0] hbdp_line_type;
   typedef struct packed {
      hbdp_word_type           data;
      logic [`HBDP_GROUPS-1:0] group_inversion_flags;
      logic [`HBDP_GROUPS-1:0] even_beat_strobes;
      logic [`HBDP_GROUPS-1:0] odd_beat_strobes;
      logic                    data_valid_n;
      logic                    data_bus_occupied_n;
   } hbdp_pins_type;
   typedef enum logic [1:0] {LS_INVALID, LS_SHARED, LS_EXCLUSIVE, LS_MODIFIED} hbdp_lstate_type;

   function automatic logic hbdp_flip(input hbdp_group_type prev, input hbdp_group_type next);
      logic [4:0] cnt;
      cnt = 5'h00;
      for (int i = 0; i < `HBDP_GRP_W; i++) begin
         cnt = cnt + {4'h0, prev[i] ^ next[i]};
      end
      return cnt > `HBDP_HALF;
   endfunction

   function automatic logic hbdp_par(input hbdp_group_type grp);
      return ^grp;
   endfunction
endpackage
`default_nettype wire

// *** testbench/hbdp_link_assertions.sv ***
/* Checker on the link pins between the two ends.
   Assumes it sees the interface signals, core_clk and srst. */
`default_nettype none
module hbdp_link_chk
   import hbdp_pkg::*;
(
   input wire logic          core_clk,               // Clock
   input wire logic          srst,                   // Reset
   input wire hbdp_pins_type pins,                   // Wire level
   input wire logic          cpu_oe_n,               // Cpu drives
   input wire logic          nb_oe_n,                // Bridge drives
   input wire logic          bus_clock_true,         // Bus clock
   input wire logic          data_return_pending_n,  // Return pending
   input wire logic          target_accepts_write_n, // Target ready
   input wire logic          snoop_hit_n,            // Clean hit
   input wire logic          snoop_dirty_match_n     // Dirty hit
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   one_driver_a: assert property (cpu_oe_n || nb_oe_n)
      else $error("both ends drive the bus");
   valid_busy_a: assert property (!cpu_oe_n || !nb_oe_n |->
      !pins.data_valid_n && !pins.data_bus_occupied_n) else $error("valid or busy off");
   drive_len_a: assert property ($fell(cpu_oe_n) |->
      ##15 !cpu_oe_n ##1 cpu_oe_n) else $error("drive not 16 cycles");
   beat_order_a: assert property ($fell(nb_oe_n) |-> ##2
      pins.even_beat_strobes == 4'h0 ##4 pins.odd_beat_strobes == 4'h0)
      else $error("strobe order wrong");
   pend_drive_a: assert property ($fell(data_return_pending_n) |->
      ##[2:40] !nb_oe_n) else $error("return not driven");
   hit_excl_a: assert property (snoop_hit_n || snoop_dirty_match_n)
      else $error("clean and dirty hit together");
   ready_ret_a: assert property (!data_return_pending_n |->
      target_accepts_write_n) else $error("ready during return");
   bclk_high_a: assert property ($rose(bus_clock_true) |->
      bus_clock_true[*8] ##1 !bus_clock_true) else $error("bus clock high time");
   cover property ($fell(cpu_oe_n));
   cover property ($fell(nb_oe_n));
   cover property (!snoop_dirty_match_n);
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
/* Bench: both ends joined by the link, lines checked against a queue.
   Assumes the package, interface and both ends are compiled first. */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import hbdp_pkg::*;
   logic            core_clk, srst, c_valid, c_done, c_defd, r_valid, r_perr, oe_n, r_pend;
   logic            s_req, l_req, n_rv, n_acc, n_def, n_wv, n_hit, n_dirty, n_lock;
   hbdp_line_type   c_line, r_line, n_rline, n_wline;
   hbdp_lstate_type s_state;
   hbdp_line_type   exp_q[$];
   int              err_total, checks_done;
   hbdp_link_if u_hbdp_link_if ();
   assign oe_n = u_hbdp_link_if.cpu_oe_n;
   hbdp_cpu_end #(.PARITY_CHECK(1'b1)) u_hbdp_cpu_end (.core_clk, .srst,
      .link(u_hbdp_link_if), .wr_valid(c_valid), .wr_ready(), .wr_line(c_line),
      .wr_lock(1'b0), .wr_done(c_done), .wr_deferred(c_defd), .rd_line(r_line),
      .rd_valid(r_valid), .rd_par_err(r_perr), .rd_pending(r_pend), .snoop_req(s_req),
      .snoop_state(s_state), .lock_req(l_req));
   hbdp_nb_end u_hbdp_nb_end (.core_clk, .srst, .link(u_hbdp_link_if), .ret_valid(n_rv),
      .ret_ready(), .ret_line(n_rline), .accept_en(n_acc), .defer_req(n_def),
      .wr_line(n_wline), .wr_valid(n_wv), .snoop_hit(n_hit), .snoop_dirty(n_dirty),
      .lock_seen(n_lock));
   hbdp_link_chk u_hbdp_link_chk (.core_clk, .srst, .pins(u_hbdp_link_if.pins),
      .cpu_oe_n(u_hbdp_link_if.cpu_oe_n), .nb_oe_n(u_hbdp_link_if.nb_oe_n),
      .bus_clock_true(u_hbdp_link_if.bus_clock_true),
      .data_return_pending_n(u_hbdp_link_if.data_return_pending_n),
      .target_accepts_write_n(u_hbdp_link_if.target_accepts_write_n),
      .snoop_hit_n(u_hbdp_link_if.snoop_hit_n),
      .snoop_dirty_match_n(u_hbdp_link_if.snoop_dirty_match_n));
   task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wt(ref logic s, input logic v);
      int n;
      n = 0;
      while (s !== v && n < 300) begin
         @(negedge core_clk);
         n++;
      end
      chk(n < 300, 1'b1);
   endtask
   // Hold below zero means the write is expected to be deferred
   task automatic wr_t(input hbdp_line_type l, input int h);
      logic [63:0] d;
      logic [3:0]  f;
      // A changed ready or defer needs the far end's synchroniser first
      if (h != 0) repeat (4) @(negedge core_clk);
      for (int g = 0; g < 4; g++) begin
         f[g] = !($countones(~l[g*16+:16]) > 8);
         d[g*16+:16] = f[g] ? l[g*16+:16] : ~l[g*16+:16];
      end
      c_line = l;
      c_valid = 1'b1;
      @(negedge core_clk);
      c_valid = 1'b0;
      if (h < 0) begin
         wt(c_defd, 1'b1);
         chk(oe_n, 1'b1);
         return;
      end
      repeat (h) @(negedge core_clk);
      chk(oe_n, 1'b1);
      n_acc = 1'b1;
      exp_q.push_back(l);
      wt(oe_n, 1'b0);
      chk(u_hbdp_link_if.pins.group_inversion_flags, f);
      chk(u_hbdp_link_if.pins.data, d);
      wt(c_done, 1'b1);
      wt(n_wv, 1'b1);
      chk(n_wline, exp_q.pop_front());
   endtask
   task automatic rd_t(input hbdp_line_type l);
      exp_q.push_back(l);
      n_rline = l;
      n_rv = 1'b1;
      @(negedge core_clk);
      n_rv = 1'b0;
      wt(r_pend, 1'b1);
      wt(r_valid, 1'b1);
      chk(r_line, exp_q.pop_front());
      chk(r_perr, 1'b0);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      #100000;
      err_total++;
      results();
   end
   initial begin
      {c_valid, s_req, l_req, n_rv, n_def, c_line, n_rline} = '0;
      n_acc = 1'b1;
      srst = 1'b1;
      s_state = LS_INVALID;
      err_total = 0;
      checks_done = 0;
      void'($urandom(32'h6d17));
      repeat (20) @(negedge core_clk);
      srst = 1'b0;
      wr_t('0, 0);
      wr_t(hbdp_line_type'({8{$urandom}}), 0);
      n_acc = 1'b0;
      wr_t(hbdp_line_type'({8{$urandom}}), 40);
      $display("write test done");
      rd_t(hbdp_line_type'({8{$urandom}}));
      rd_t('1);
      $display("read test done");
      n_acc = 1'b0;
      n_def = 1'b1;
      wr_t(hbdp_line_type'({8{$urandom}}), -1);
      n_def = 1'b0;
      n_acc = 1'b1;
      $display("defer test done");
      for (int s = 0; s < 5; s++) begin
         s_state = hbdp_lstate_type'(s[1:0]);
         s_req = (s < 4);
         l_req = s[0];
         repeat (5) @(negedge core_clk);
         chk(n_hit, s == 1 || s == 2);
         chk(n_dirty, s == 3);
         chk(n_lock, s[0]);
      end
      $display("snoop test done");
      results();
   end
endmodule
`default_nettype wire
